// ---- src/dpw_pkg.sv ----
// Package: constants shared by the digipot serial device end and the host end.
// Assumes a 16-bit frame: command in bits 13:10, data in bits 9:0.
package dpw_pkg;
  localparam int          FRAME_BITS      = 16;
  localparam int          DATA_BITS       = 10;
  localparam int          CMD_LSB         = 10;
  localparam int          CMD_BITS        = 4;
  localparam int          CTRL_BITS       = 4;
  localparam int          OTP_DEPTH       = 20;
  localparam int          OTP_PTR_BITS    = 5;
  localparam logic [3:0]  CMD_NOP         = 4'h0;
  localparam logic [3:0]  CMD_WRITE_WIPER = 4'h1;
  localparam logic [3:0]  CMD_READ_WIPER  = 4'h2;
  localparam logic [3:0]  CMD_STORE_OTP   = 4'h3;
  localparam logic [3:0]  CMD_SOFT_RESET  = 4'h4;
  localparam logic [3:0]  CMD_READ_OTP    = 4'h5;
  localparam logic [3:0]  CMD_WRITE_CTRL  = 4'h6;
  localparam logic [3:0]  CMD_READ_CTRL   = 4'h7;
  localparam logic [15:0] SDO_HIZ_WORD    = 16'h8001;
  localparam logic [15:0] NOP_WORD        = 16'h0000;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;
  localparam int          CTRL_OTP_EN     = 0;
  localparam int          CTRL_UNLOCK     = 1;
  localparam int          CTRL_CAL_DIS    = 2;
  localparam int          CTRL_FUSE_OK    = 3;
  localparam logic [4:0]  OTP_STAT_LO     = 5'h14;
  localparam logic [4:0]  OTP_STAT_HI     = 5'h15;
  localparam int          SCLK_DIV        = 20;
  localparam int          CHAIN_DEVICES   = 1;
endpackage : dpw_pkg

// ---- src/dpw_link_if.sv ----
// Interface: serial link between host and digipot device end.
// Resolves the open-drain data out here with a modelled pull-up: sdo_line is low only while sdo_oe drives a low.
`timescale 1ns/100ps
`default_nettype none
interface dpw_link_if;
  logic sclk;
  logic sync_n;
  logic din;
  logic sdo_o;
  logic sdo_oe;
  logic sdo_line;
  assign sdo_line = ~(sdo_oe & ~sdo_o);
  modport device (input sclk, input sync_n, input din, input sdo_line, output sdo_o, output sdo_oe);
  modport host   (output sclk, output sync_n, output din, input sdo_line);
endinterface : dpw_link_if
`default_nettype wire

// ---- src/dpw_sync2.sv ----
// Two-flop synchroniser for link pins entering the reference clock domain.
// Assumes asynchronous inputs; output is two edges late.
`timescale 1ns/100ps
`default_nettype none
module dpw_sync2
  import dpw_pkg::*;
#(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      meta     <= INIT;
      sync_out <= INIT;
    end else begin
      meta     <= async_in;
      sync_out <= meta;
    end
  end
endmodule : dpw_sync2
`default_nettype wire

// ---- src/dpw_device.sv ----
// Device end: shift register, wiper code register, OTP wiper memory, control bits, open-drain readback.
// Assumes link pins arrive asynchronously and are sampled by ref_clk_in (much faster than sclk).
//
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [RQ1] Reset pin rise loads latest OTP value
// [RQ2] Command 4 performs same reset
// [RQ3] Empty OTP resets wiper to midscale
// [RQ4] Every reset restores control defaults
// [RQ5] Control defaults are all zero
// [RQ6] Commands 2,5,7 read wiper, OTP, control
// [RQ7] Readback appears next frame, low 10 bits
// [RQ8] Output data changes on sclk rise
// [RQ9] Output is open drain: low or released
// [RQ10] 0x8001 then NOP floats output
// [RQ11] Chain of two shifts 32 bits
// [RQ12] Host holds select low whole frame
// [RQ13] Host may slow clock for chains
// [RQ14] Code decodes to one tap
// [RQ15] Calibration mode active by default, bit-controlled
// [RQ16] Calibration bit zero means calibration mode
// [RQ17] Divider use should disable calibration
// [RQ18] Power-on preset loads from OTP
// [RQ19] Wiper width parameter, upper bits ignored
module dpw_device
  import dpw_pkg::*;
#(
  parameter int CODE_BITS = 10,
  parameter int TAPS      = 1 << CODE_BITS
) (
  input  wire logic                 ref_clk_in,
  input  wire logic                 rst_in,
  dpw_link_if.device                link,
  input  wire logic                 hw_reset_n_in,
  output logic      [CODE_BITS-1:0] wiper_code_register_out,
  output logic      [TAPS-1:0]      wiper_tap_out,
  output logic                      tolerance_cal_active_out,
  output logic                      otp_program_enable_out,
  output logic                      wiper_write_unlock_out,
  output logic                      fuse_program_ok_out,
  output logic                      sdo_hiz_out,
  output logic      [OTP_PTR_BITS-1:0] otp_used_out
);
  localparam logic [CODE_BITS-1:0] MIDSCALE = CODE_BITS'(TAPS / 2);

  logic [2:0] pins_s;
  logic       sclk_d;
  logic       sync_n_d;
  logic       rst_pin_d;
  dpw_sync2 #(.WIDTH(3), .INIT(3'h7)) u_sync (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   ({link.sclk, link.sync_n, hw_reset_n_in}),
    .sync_out   (pins_s)
  );
  wire sclk_s   = pins_s[2];
  wire sync_n_s = pins_s[1];
  wire rst_pin  = pins_s[0];
  wire din_s;
  dpw_sync2 #(.WIDTH(1)) u_din (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   (link.din),
    .sync_out   (din_s)
  );

  wire sclk_rise = sclk_s & ~sclk_d;
  wire sclk_fall = ~sclk_s & sclk_d;
  wire frame_end = sync_n_s & ~sync_n_d;
  wire frame_on  = ~sync_n_s;

  logic [FRAME_BITS-1:0]   shreg;
  logic [FRAME_BITS-1:0]   out_word;
  logic [DATA_BITS-1:0]    otp_mem [OTP_DEPTH];
  logic [OTP_PTR_BITS-1:0] otp_count;
  logic [CTRL_BITS-1:0]    ctrl;
  logic [CODE_BITS-1:0]    wiper;
  logic                    hiz_armed;
  logic                    hiz;
  logic                    sdo_bit;
  logic                    por_pending;

  wire [CMD_BITS-1:0]  cmd   = shreg[CMD_LSB +: CMD_BITS];
  wire [DATA_BITS-1:0] data  = shreg[DATA_BITS-1:0];
  wire [CODE_BITS-1:0] code  = data[CODE_BITS-1:0]; // see [RQ19]
  wire [OTP_PTR_BITS-1:0] sel = data[OTP_PTR_BITS-1:0];
  wire otp_empty = (otp_count == '0);
  wire [CODE_BITS-1:0] otp_latest = otp_empty ? MIDSCALE // see [RQ3]
                                   : otp_mem[otp_count - OTP_PTR_BITS'(1)][CODE_BITS-1:0];
  wire rst_pin_rise = rst_pin & ~rst_pin_d;
  wire do_cmd       = frame_end & ~hiz_armed;
  wire soft_reset   = do_cmd & (cmd == CMD_SOFT_RESET);
  wire any_reset    = rst_pin_rise | soft_reset | por_pending; // see [RQ1] see [RQ2] see [RQ18]
  wire otp_full     = (otp_count == OTP_PTR_BITS'(OTP_DEPTH));
  wire do_store     = do_cmd & (cmd == CMD_STORE_OTP) & ctrl[CTRL_OTP_EN] & ~otp_full;

  function automatic logic [DATA_BITS-1:0] thermo(input int n);
    logic [DATA_BITS-1:0] t;
    t = '0;
    for (int i = 0; i < DATA_BITS; i++) t[i] = (i < n);
    return t;
  endfunction : thermo

  // Readback word for the next frame
  logic [DATA_BITS-1:0] rd_data;
  always_comb begin
    rd_data = '0;
    unique case (cmd)
      CMD_READ_WIPER: rd_data = DATA_BITS'(wiper);
      CMD_READ_CTRL:  rd_data = DATA_BITS'(ctrl);
      CMD_READ_OTP: begin
        if (sel == OTP_STAT_LO) rd_data = thermo(int'(otp_count));
        else if (sel == OTP_STAT_HI) rd_data = thermo(int'(otp_count) - DATA_BITS);
        else if (sel < OTP_PTR_BITS'(OTP_DEPTH)) rd_data = otp_mem[sel];
      end
      default: rd_data = shreg[DATA_BITS-1:0];
    endcase
  end
  wire is_read = (cmd == CMD_READ_WIPER) | (cmd == CMD_READ_OTP) | (cmd == CMD_READ_CTRL);
  wire [FRAME_BITS-1:0] next_out_word = is_read ? {{(FRAME_BITS-DATA_BITS){1'b0}}, rd_data} // see [RQ6] see [RQ7]
                                                : shreg; // see [RQ11]

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      sclk_d <= 1'b1; sync_n_d <= 1'b1; rst_pin_d <= 1'b1;
      shreg <= '0; out_word <= '0; sdo_bit <= 1'b1;
      hiz_armed <= 1'b0; hiz <= 1'b0; por_pending <= 1'b1;
      otp_count <= '0; ctrl <= CTRL_RESET; wiper <= MIDSCALE;
    end else begin
      sclk_d <= sclk_s; sync_n_d <= sync_n_s; rst_pin_d <= rst_pin;
      por_pending <= 1'b0;
      if (frame_on && sclk_fall) shreg <= {shreg[FRAME_BITS-2:0], din_s};
      if (frame_on && sclk_rise) begin
        sdo_bit  <= out_word[FRAME_BITS-1]; // see [RQ8]
        out_word <= {out_word[FRAME_BITS-2:0], 1'b0};
      end
      if (frame_end) begin
        // Top bit goes out now; each following rise presents the next one
        out_word <= {next_out_word[FRAME_BITS-2:0], 1'b0};
        sdo_bit  <= next_out_word[FRAME_BITS-1];
        hiz_armed <= (shreg == SDO_HIZ_WORD);
        if (hiz_armed && shreg == NOP_WORD) hiz <= 1'b1; // see [RQ10]
        else if (!hiz_armed) hiz <= 1'b0;
      end
      if (do_store) begin
        otp_mem[otp_count] <= DATA_BITS'(wiper);
        otp_count <= otp_count + OTP_PTR_BITS'(1);
        ctrl[CTRL_FUSE_OK] <= 1'b1;
      end
      if (do_cmd && cmd == CMD_WRITE_CTRL) ctrl <= (data[CTRL_BITS-1:0] & ~(CTRL_BITS'(1) << CTRL_FUSE_OK))
                                                  | (ctrl & (CTRL_BITS'(1) << CTRL_FUSE_OK));
      if (do_cmd && cmd == CMD_WRITE_WIPER && ctrl[CTRL_UNLOCK]) wiper <= code;
      if (any_reset) begin
        wiper <= otp_latest; // see [RQ1] see [RQ18]
        ctrl  <= CTRL_RESET; // see [RQ4] see [RQ5]
      end
    end
  end

  // One-hot tap select
  genvar g;
  generate
    for (g = 0; g < TAPS; g++) begin : g_tap
      assign wiper_tap_out[g] = (wiper == CODE_BITS'(g)); // see [RQ14]
    end
  endgenerate

  assign link.sdo_o  = 1'b0;
  assign link.sdo_oe = ~hiz & ~sdo_bit; // see [RQ9]
  assign wiper_code_register_out  = wiper;
  assign tolerance_cal_active_out = ~ctrl[CTRL_CAL_DIS]; // see [RQ15] see [RQ16]
  assign otp_program_enable_out   = ctrl[CTRL_OTP_EN];
  assign wiper_write_unlock_out   = ctrl[CTRL_UNLOCK];
  assign fuse_program_ok_out      = ctrl[CTRL_FUSE_OK];
  assign sdo_hiz_out              = hiz;
  assign otp_used_out             = otp_count;
endmodule : dpw_device
`default_nettype wire

// ---- src/dpw_host.sv ----
// Host end: register-driven frame master; sends 16 bits per chained device, captures the returned words.
// Assumes a plain register port on ref_clk_in; sdo_line returns asynchronously.
`timescale 1ns/100ps
`default_nettype none
module dpw_host
  import dpw_pkg::*;
#(
  parameter int DIV     = SCLK_DIV,
  parameter int DEVICES = CHAIN_DEVICES
) (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_in,
  dpw_link_if.host         link,
  input  wire logic [1:0]  addr_in,
  input  wire logic [31:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [31:0] rdata_out
);
  // Register offsets: 0 tx word, 1 rx word, 2 status(bit0 busy)
  localparam logic [1:0] REG_TX = 2'h0;
  localparam logic [1:0] REG_RX = 2'h1;
  localparam logic [1:0] REG_ST = 2'h2;
  localparam int NBITS = FRAME_BITS * DEVICES;
  localparam int CW    = $clog2(NBITS + 1);
  localparam int DW    = $clog2(DIV + 1);

  typedef enum logic [1:0] {HS_IDLE, HS_LOW, HS_HIGH, HS_END} dpw_hstate_t;
  dpw_hstate_t state;
  logic [NBITS-1:0] tx;
  logic [NBITS-1:0] rx;
  logic [CW-1:0]    bits;
  logic [DW-1:0]    div;
  logic             sclk;
  logic             sync_n;
  logic             sdo_s;
  dpw_sync2 #(.WIDTH(1), .INIT(1'b1)) u_sdo (
    .ref_clk_in (ref_clk_in),
    .rst_in     (rst_in),
    .async_in   (link.sdo_line),
    .sync_out   (sdo_s)
  );
  wire tick  = (div == DW'(DIV - 1));
  wire start = wr_in & (addr_in == REG_TX) & (state == HS_IDLE);

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      state <= HS_IDLE; tx <= '0; rx <= '0; bits <= '0; div <= '0;
      sclk <= 1'b1; sync_n <= 1'b1; rdata_out <= '0;
    end else begin
      div <= (state == HS_IDLE || tick) ? '0 : div + DW'(1);
      unique case (state)
        HS_IDLE: if (start) begin
          tx <= wdata_in[NBITS-1:0]; bits <= '0; sync_n <= 1'b0; state <= HS_HIGH;
          sclk <= 1'b1;
        end
        HS_HIGH: if (tick) begin
          sclk <= 1'b0; state <= HS_LOW;
        end
        HS_LOW: if (tick) begin
          rx <= {rx[NBITS-2:0], sdo_s};
          tx <= {tx[NBITS-2:0], 1'b0};
          bits <= bits + CW'(1);
          sclk <= 1'b1;
          state <= (bits == CW'(NBITS - 1)) ? HS_END : HS_HIGH;
        end
        HS_END: if (tick) begin
          sync_n <= 1'b1; state <= HS_IDLE; // see [RQ12]
        end
      endcase
      rdata_out <= (rd_in && addr_in == REG_RX) ? 32'(rx)
                 : (rd_in && addr_in == REG_ST) ? {31'h0, state != HS_IDLE} : 32'h0;
    end
  end
  assign link.sclk   = sclk;
  assign link.sync_n = sync_n;
  assign link.din    = tx[NBITS-1]; // see [RQ11] see [RQ13]
endmodule : dpw_host
`default_nettype wire

// ---- verification/dpw_link_monitor.sv ----
// Checker for the serial link between host end and device end.
// Assumes it sits beside the link interface in the bench.
`timescale 1ns/100ps
`default_nettype none
module dpw_link_monitor (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic sclk,
  input wire logic sync_n,
  input wire logic din,
  input wire logic sdo_o,
  input wire logic sdo_oe,
  input wire logic sdo_line
);
  logic [5:0] rise_cnt;
  logic       sclk_q;
  // Counts clock rises inside one frame
  always_ff @(posedge ref_clk_in) begin
    sclk_q <= sclk;
    if (rst_in || sync_n) rise_cnt <= 6'h00;
    else if (sclk && !sclk_q) rise_cnt <= rise_cnt + 6'h01;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  sequence frame_open;
    $fell(sync_n) ##0 sclk;
  endsequence
  AST_SDO_PULLS_LOW: assert property (sdo_oe |-> !sdo_o)
    else $error("sdo driven high");
  AST_SDO_RELEASED_HIGH: assert property (!sdo_oe |-> sdo_line)
    else $error("released sdo not high");
  AST_RESET_RELEASES_SDO: assert property ($fell(rst_in) |-> !sdo_oe)
    else $error("sdo held after reset");
  AST_SDO_ON_SCLK_RISE: assert property ((!sync_n && !$past(sync_n, 4) && $changed(sdo_oe)) |->
    (sclk || $past(sclk) || $past(sclk, 2) || $past(sclk, 3) || $past(sclk, 4)))
    else $error("sdo changed away from clock rise");
  AST_SCLK_STILL_IDLE: assert property ((sync_n && $past(sync_n)) |-> $stable(sclk))
    else $error("clock moved outside frame");
  AST_SCLK_HIGH_TIME: assert property ($rose(sclk) |=> sclk [* 3])
    else $error("clock high phase too short");
  AST_FRAME_OPEN_HOLD: assert property (frame_open |=> !sync_n [* 7])
    else $error("select released early");
  AST_FRAME_BITS: assert property ($rose(sync_n) |-> rise_cnt == 6'h10)
    else $error("frame bit count wrong");
endmodule : dpw_link_monitor
`default_nettype wire

// ---- verification/digipot_wiper_serial_control_tb.sv ----
// Bench: host and device ends on one link, compared with a reference model.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/100ps
`default_nettype none
module digipot_wiper_serial_control_tb;
  import dpw_pkg::*;
  logic          ref_clk_in    = 1'b0;
  logic          rst_in        = 1'b1;
  logic          hw_reset_n_in = 1'b1;
  logic [1:0]    addr_in       = 2'h0;
  logic [31:0]   wdata_in      = 32'h0;
  logic          wr_in         = 1'b0;
  logic          rd_in         = 1'b0;
  logic [31:0]   rdata_out;
  logic [9:0]    wiper;
  logic [1023:0] tap;
  logic          cal, oen, unl, fok, hiz;
  logic [4:0]    used;
  int            n_errors = 0;
  int            samples_checked = 0;
  int            seed = 32'h80FE7046;
  int            m_wiper = 512, m_ctrl = 0, m_hiz = 0, m_pend = 0, exp_lo = -1;
  int            otp[$];
  dpw_link_if link();
  dpw_host #(.DIV(4)) u_dpw_host (.ref_clk_in, .rst_in, .link, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out);
  dpw_device u_dpw_device (.ref_clk_in, .rst_in, .link, .hw_reset_n_in, .wiper_code_register_out(wiper),
    .wiper_tap_out(tap), .tolerance_cal_active_out(cal), .otp_program_enable_out(oen),
    .wiper_write_unlock_out(unl), .fuse_program_ok_out(fok), .sdo_hiz_out(hiz), .otp_used_out(used));
  dpw_link_monitor u_dpw_link_monitor (.ref_clk_in, .rst_in, .sclk(link.sclk), .sync_n(link.sync_n),
    .din(link.din), .sdo_o(link.sdo_o), .sdo_oe(link.sdo_oe), .sdo_line(link.sdo_line));
  initial forever #2 ref_clk_in = ~ref_clk_in;
  task automatic close_out;
    $display("Checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic check(string what, logic [31:0] seen, logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, expv, seen);
    end
  endtask : check
  task automatic wr(logic [1:0] a, logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in  <= a;
    wdata_in <= d;
    wr_in    <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask : wr
  task automatic rd(logic [1:0] a, output logic [31:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in   <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask : rd
  task automatic chk_state;
    check("wiper", wiper, m_wiper);
    check("tap", tap === (1024'h1 << m_wiper), 1);
    check("ctrl", {fok, unl, oen}, {m_ctrl[3], m_ctrl[1:0]});
    check("cal", cal, !m_ctrl[2]);
    check("hiz", hiz, m_hiz);
    check("used", used, otp.size());
  endtask : chk_state
  task automatic m_reset;
    m_wiper = otp.size() ? otp[$] : 512;
    m_ctrl  = 0;
    exp_lo  = -1;
  endtask : m_reset
  task automatic frame(logic [15:0] w);
    logic [31:0] d;
    int          t;
    wr(2'h0, {16'h0, w});
    repeat (4) @(posedge ref_clk_in);
    d = 32'h1;
    for (int i = 0; i < 400 && d[0]; i++) rd(2'h2, d);
    check("busy", d[0], 0);
    repeat (12) @(posedge ref_clk_in);
    rd(2'h1, d);
    if (exp_lo >= 0) check("rx", d[9:0], exp_lo[9:0]);
    exp_lo = w[9:0];
    t = otp.size() > 10 ? 10 : otp.size();
    if (m_pend) begin
      m_pend = 0;
      exp_lo = -1;
      if (w == NOP_WORD) begin
        m_hiz  = 1;
        exp_lo = 10'h3FF;
      end
    end else if (w == SDO_HIZ_WORD) begin
      m_pend = 1;
      exp_lo = -1;
    end else begin
      m_hiz = 0;
      case (w[13:10])
        4'h1: if (m_ctrl[1]) m_wiper = w[9:0];
        4'h2: exp_lo = m_wiper;
        4'h3: if (m_ctrl[0]) begin
          otp.push_back(m_wiper);
          m_ctrl[3] = 1'b1;
        end
        4'h4: m_reset();
        4'h5: exp_lo = (w[4:0] == OTP_STAT_LO) ? (1 << t) - 1 : (w[4:0] < otp.size() ? otp[w[4:0]] : -1);
        4'h6: m_ctrl = (m_ctrl & 8) | w[2:0];
        4'h7: exp_lo = m_ctrl;
        default: ;
      endcase
    end
    chk_state();
  endtask : frame
  initial begin
    repeat (16) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge ref_clk_in);
    chk_state();
    frame({6'h01, 10'($random(seed))});
    frame(16'h1802);
    frame({6'h01, 10'($random(seed))});
    frame(16'h0800);
    frame(16'h1C00);
    frame(16'h1803);
    frame(16'h0C00);
    frame(16'h1414);
    frame(16'h1400);
    frame(16'h1806);
    frame({6'h01, 10'($random(seed))});
    frame(16'h1000);
    frame(16'h0800);
    frame(16'h1802);
    frame({6'h01, 10'($random(seed))});
    @(posedge ref_clk_in);
    hw_reset_n_in <= 1'b0;
    repeat (8) @(posedge ref_clk_in);
    hw_reset_n_in <= 1'b1;
    repeat (12) @(posedge ref_clk_in);
    m_reset();
    chk_state();
    frame(SDO_HIZ_WORD);
    frame(NOP_WORD);
    frame(NOP_WORD);
    frame(NOP_WORD);
    close_out();
  end
  // About twenty frames need under 20 us
  initial begin
    #200000;
    n_errors++;
    close_out();
  end
endmodule : digipot_wiper_serial_control_tb
`default_nettype wire
